//--- common/jfr_pkg.sv
// Shared constants and carrier types for the jog and fixed-speed reference ramp.
// Assumes a single 40 MHz controller clock and 16-bit signed rpm references.
package jfr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and time base.
  ////////////////////////////////////////////////////////////////////////////////
  // Controller clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS       = 25;
  // One stored time count is one hundredth of a second, in nanoseconds.
  localparam int unsigned TIME_UNIT_NS        = 10_000_000;
  // Clock cycles per stored time count.
  localparam int unsigned CYC_PER_TIME_UNIT   = TIME_UNIT_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Ranges and reset values.
  ////////////////////////////////////////////////////////////////////////////////
  // Stored counts per second of ramp time.
  localparam logic [15:0] TIME_COUNTS_PER_S   = 16'h0064;
  // Longest ramp time, 300 s in stored counts.
  localparam logic [15:0] TIME_MAX            = 16'h7530;
  // Reset ramp time, 20 s in stored counts.
  localparam logic [15:0] TIME_DEFAULT        = 16'h07d0;
  // Magnitude limit of any rpm setting, 10000 rpm.
  localparam logic [15:0] RPM_MAX             = 16'h2710;
  // Reset value of a speed setting, 0 rpm.
  localparam logic [15:0] SPEED_DEFAULT       = 16'h0000;
  // Internal limit factor numerator and denominator.
  localparam logic [31:0] LIMIT_NUM           = 32'h0000_7fff;
  localparam logic [31:0] LIMIT_DEN           = 32'h0000_4e20;
  // Control word bit positions of the two jog requests.
  localparam int unsigned MCW_JOG_ONE_BIT     = 8;
  localparam int unsigned MCW_JOG_TWO_BIT     = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  ////////////////////////////////////////////////////////////////////////////////
  // Retained jog settings, times in hundredths of a second, speeds in rpm.
  typedef struct packed {
    logic        [15:0] jog_accel_duration;
    logic        [15:0] jog_decel_duration;
    logic signed [15:0] constant_speed_one;
    logic signed [15:0] constant_speed_two;
  } jfr_settings_t;

  // Source of the ramp target.
  typedef enum logic [1:0] {
    JFR_SRC_MAIN  = 2'b00,
    JFR_SRC_ONE   = 2'b01,
    JFR_SRC_TWO   = 2'b10
  } jfr_source_t;

endpackage

//--- hw/jfr_ramp.sv
// Jog and fixed-speed reference stage with its own speed ramp.
// Assumes settings are restored from retained storage by a load strobe after power-up,
// and that main control word and path settings come from logic on the same clock.
`timescale 1ns/10ps
module jfr_ramp
  import jfr_pkg::*;
#(
  parameter int unsigned TIME_UNIT_CYCLES = CYC_PER_TIME_UNIT
) (
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  input  wire logic               jog_command_one_in,
  input  wire logic               jog_command_two_in,
  input  wire logic        [15:0] main_control_word_in,
  input  wire logic signed [15:0] main_speed_setpoint_in,
  input  wire logic               path_one_multiplexer_in,
  input  wire logic               path_one_selector_in,
  input  wire logic               path_two_multiplexer_in,
  input  wire logic               path_two_selector_in,
  input  wire logic        [15:0] active_speed_scale_in,
  input  wire logic        [7:0]  ramp_duration_multiplier_in,
  input  wire logic        [15:0] normal_accel_duration_in,
  input  wire logic        [15:0] normal_decel_duration_in,
  input  wire jfr_settings_t      settings_in,
  input  wire logic               settings_load_in,
  output jfr_settings_t           settings_out,
  output logic signed [15:0]      applied_speed_setpoint_out,
  output logic signed [15:0]      ramp_input_out,
  output logic signed [15:0]      ramped_reference_out,
  output logic                    jog_times_active_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  ////////////////////////////////////////////////////////////////////////////////

  // Clamps a signed rpm value symmetrically to plus or minus a magnitude.
  function automatic logic signed [15:0] clamp_ref(input logic signed [15:0] v,
                                                   input logic        [15:0] lim);
    logic signed [16:0] hi;
    logic signed [16:0] lo;
    logic signed [16:0] vx;
    begin
      hi = $signed({1'b0, lim});
      lo = -hi;
      vx = {v[15], v};
      if (vx > hi) begin
        clamp_ref = hi[15:0];
      end else if (vx < lo) begin
        clamp_ref = lo[15:0];
      end else begin
        clamp_ref = v;
      end
    end
  endfunction

  // Limits a stored time count to the longest allowed ramp time.
  function automatic logic [15:0] clamp_time(input logic [15:0] t);
    begin
      clamp_time = (t > TIME_MAX) ? TIME_MAX : t;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the jog command inputs.
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] jog_one_sync_r;  // First stage bit 0, second stage bit 1.
  logic [1:0] jog_two_sync_r;  // Same layout for the second command.

  // Two flip-flops per pin before any logic looks at the command.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      jog_one_sync_r <= 2'h0;
      jog_two_sync_r <= 2'h0;
    end else begin
      jog_one_sync_r <= {jog_one_sync_r[0], jog_command_one_in};
      jog_two_sync_r <= {jog_two_sync_r[0], jog_command_two_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Retained settings.
  ////////////////////////////////////////////////////////////////////////////////
  jfr_settings_t settings_r;    // Settings as held.
  jfr_settings_t settings_nxt;  // Range-checked copy of the incoming settings.

  assign settings_nxt.jog_accel_duration = clamp_time(settings_in.jog_accel_duration);
  assign settings_nxt.jog_decel_duration = clamp_time(settings_in.jog_decel_duration);
  assign settings_nxt.constant_speed_one = clamp_ref(settings_in.constant_speed_one, RPM_MAX);
  assign settings_nxt.constant_speed_two = clamp_ref(settings_in.constant_speed_two, RPM_MAX);

  // retained time storage
  // Settings change only on reset or a load strobe, so a restore after power-up recovers them.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      settings_r.jog_accel_duration <= TIME_DEFAULT;
      settings_r.jog_decel_duration <= TIME_DEFAULT;
      settings_r.constant_speed_one <= SPEED_DEFAULT;
      settings_r.constant_speed_two <= SPEED_DEFAULT;
    end else if (settings_load_in) begin
      settings_r <= settings_nxt;
    end
  end

  assign settings_out = settings_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference scaling and selection.
  ////////////////////////////////////////////////////////////////////////////////
  logic        [31:0] limit_wide;   // Scale times 32767/20000, full width.
  logic        [15:0] limit_rpm;    // Internal limit magnitude.
  logic signed [15:0] main_lim;     // Main setpoint after both clamps.
  logic signed [15:0] speed_one_lim;  // First fixed speed after the scale clamp.
  logic signed [15:0] speed_two_lim;  // Second fixed speed after the scale clamp.
  logic               path_on;      // Either reference path is connected.
  logic               jog_one;      // First jog request from pin or control word.
  logic               jog_two;      // Second jog request from pin or control word.
  logic               jog_active;   // Any jog request.
  jfr_source_t        source;       // Chosen ramp source.
  logic signed [15:0] target;       // Ramp target this cycle.

  assign limit_wide = 32'(active_speed_scale_in) * LIMIT_NUM / LIMIT_DEN;
  assign limit_rpm  = (limit_wide > 32'h0000_ffff) ? 16'hffff : limit_wide[15:0];

  assign main_lim      = clamp_ref(clamp_ref(main_speed_setpoint_in, RPM_MAX), limit_rpm);
  assign speed_one_lim = clamp_ref(settings_r.constant_speed_one, limit_rpm);
  assign speed_two_lim = clamp_ref(settings_r.constant_speed_two, limit_rpm);

  assign path_on = (path_one_multiplexer_in & path_one_selector_in) |
                   (path_two_multiplexer_in & path_two_selector_in);

  assign jog_one    = jog_one_sync_r[1] | main_control_word_in[MCW_JOG_ONE_BIT];
  assign jog_two    = jog_two_sync_r[1] | main_control_word_in[MCW_JOG_TWO_BIT];
  assign jog_active = jog_one | jog_two;

  // fixed speed override
  // The first request wins when both are present.
  assign source = jog_one ? JFR_SRC_ONE : (jog_two ? JFR_SRC_TWO : JFR_SRC_MAIN);

  always_comb begin
    case (source)
      JFR_SRC_ONE:  target = speed_one_lim;
      JFR_SRC_TWO:  target = speed_two_lim;
      JFR_SRC_MAIN: target = applied_speed_setpoint_out;
      default:      target = applied_speed_setpoint_out;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp time selection.
  ////////////////////////////////////////////////////////////////////////////////
  logic               moving_up;   // Output must rise toward the target.
  logic               away_zero;   // Movement grows the magnitude: acceleration.
  logic        [15:0] time_sel;    // Chosen ramp time in stored counts.
  logic        [7:0]  mult_eff;    // Multiplier, zero taken as one.
  logic        [63:0] step_den;    // Cycles times scale per one rpm step.
  logic        [63:0] acc_sum;     // Accumulator plus this cycle's share.
  logic               step_due;    // Accumulator has crossed the threshold.
  logic               at_target;   // Output equals the target.
  logic        [63:0] acc_r;       // Fractional progress toward the next 1 rpm step.

  assign moving_up = target > ramped_reference_out;
  assign away_zero = moving_up ? (ramped_reference_out >= 16'sh0000)
                               : (ramped_reference_out <= 16'sh0000);

  assign time_sel = jog_active
                  ? (away_zero ? settings_r.jog_accel_duration : settings_r.jog_decel_duration)
                  : (away_zero ? normal_accel_duration_in : normal_decel_duration_in);

  assign mult_eff = (ramp_duration_multiplier_in == 8'h00) ? 8'h01
                                                           : ramp_duration_multiplier_in;
  assign step_den = 64'(time_sel) * 64'(mult_eff) * 64'(TIME_UNIT_CYCLES);

  assign acc_sum   = acc_r + 64'(active_speed_scale_in);
  assign step_due  = acc_sum >= step_den;
  assign at_target = ramped_reference_out == target;

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp integrator.
  ////////////////////////////////////////////////////////////////////////////////
  // jog ramp slope
  // Adding the scale each cycle against time times cycles gives scale per time.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_r                <= 64'h0;
      ramped_reference_out <= 16'sh0000;
    end else if (at_target) begin
      acc_r <= 64'h0;
    end else if (time_sel == 16'h0000) begin
      acc_r                <= 64'h0;
      ramped_reference_out <= target;
    end else if (step_due) begin
      acc_r                <= acc_sum - step_den;
      ramped_reference_out <= moving_up ? ramped_reference_out + 16'sh0001
                                        : ramped_reference_out - 16'sh0001;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // Registered views of the selected references and the jog time flag.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      applied_speed_setpoint_out <= 16'sh0000;
      ramp_input_out             <= 16'sh0000;
      jog_times_active_out       <= 1'b0;
    end else begin
      applied_speed_setpoint_out <= path_on ? main_lim : 16'sh0000;
      ramp_input_out             <= target;
      jog_times_active_out       <= jog_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence jog_one_seen_s;
    jog_one;
  endsequence
  sequence speed_one_fed_s;
    ##1 ramp_input_out == $past(speed_one_lim);
  endsequence

  // first speed fed
  // A first jog request puts the first fixed speed on the ramp input next cycle.
  speed_one_sel_a: assert property (jog_one_seen_s |-> speed_one_fed_s)
    else $error("Ramp input is not the first fixed speed.");
  // second speed fed
  // The second request counts only while the first one is absent.
  speed_two_sel_a: assert property (!jog_one && jog_two |=>
                                    ramp_input_out == $past(speed_two_lim))
    else $error("Ramp input is not the second fixed speed.");
  // main path passes
  // With no jog request the intermediate setpoint feeds the ramp.
  main_pass_a: assert property (!jog_active |=>
                                ramp_input_out == $past(applied_speed_setpoint_out))
    else $error("Ramp input does not follow the intermediate setpoint.");
  // jog flag follows
  // The jog time flag rises and falls one cycle after the request.
  jog_times_a: assert property (jog_active |=> jog_times_active_out)
    else $error("Jog time flag missing while jogging.");
  jog_release_a: assert property (!jog_active |=> !jog_times_active_out)
    else $error("Jog time flag left set after jogging.");
  // path gating
  // Nothing reaches the applied setpoint unless a path is connected.
  path_gate_a: assert property (!path_on |=> applied_speed_setpoint_out == 16'sh0000)
    else $error("Setpoint applied with no path connected.");
  // main setpoint limit
  // Sign-extended compares keep a negative setpoint from reading as a large one.
  ref_limit_a: assert property ($signed({main_lim[15], main_lim}) <=
                                $signed({1'b0, limit_rpm}) &&
                                $signed({main_lim[15], main_lim}) >=
                                -$signed({1'b0, limit_rpm}))
    else $error("Main setpoint exceeds the internal limit.");
  // stored time range
  // Held jog times never exceed the longest allowed ramp time.
  time_range_a: assert property (settings_r.jog_accel_duration <= TIME_MAX &&
                                 settings_r.jog_decel_duration <= TIME_MAX)
    else $error("Stored jog time above its range.");
  // one rpm steps
  // A nonzero ramp time never lets the output jump by more than one rpm.
  step_size_a: assert property (time_sel != 16'h0000 && !at_target |=>
      (ramped_reference_out - $past(ramped_reference_out)) <= 16'sh0001 &&
      (ramped_reference_out - $past(ramped_reference_out)) >= -16'sh0001)
    else $error("Ramp moved by more than one rpm in a cycle.");
  // zero time jump
  // A zero jog time lands the output on the target in one cycle.
  zero_time_a: assert property (jog_active && time_sel == 16'h0000 && !at_target |=>
                                ramped_reference_out == $past(target))
    else $error("Zero jog time did not jump to the target.");
  // fixed speed limits
  // Both fixed speeds stay inside the symmetric internal limit.
  speed_clamp_a: assert property ($signed({speed_one_lim[15], speed_one_lim}) <=
                                  $signed({1'b0, limit_rpm}) &&
                                  $signed({speed_one_lim[15], speed_one_lim}) >=
                                  -$signed({1'b0, limit_rpm}))
    else $error("First fixed speed exceeds the internal limit.");
  speed_two_clamp_a: assert property ($signed({speed_two_lim[15], speed_two_lim}) <=
                                      $signed({1'b0, limit_rpm}) &&
                                      $signed({speed_two_lim[15], speed_two_lim}) >=
                                      -$signed({1'b0, limit_rpm}))
    else $error("Second fixed speed exceeds the internal limit.");

endmodule

//--- tb/jfr_ctrl_model.sv
// Stand-in for the downstream speed ramp consumer and speed controller.
// Assumes the ramped reference is registered on the rising edge of clock_in.
`timescale 1ns/10ps
module jfr_ctrl_model (
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  input  wire logic signed [15:0] ramped_reference_in,
  output logic             [15:0] big_step_count_out
);
  logic signed [15:0] last_r;  // Reference seen at the previous edge.
  logic signed [16:0] delta;   // Change since the previous edge.

  ////////////////////////////////////////////////////////////////////////////////
  // The controller tracks the reference and counts any jump above one rpm.
  ////////////////////////////////////////////////////////////////////////////////
  assign delta = 17'(ramped_reference_in) - 17'(last_r);
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_r             <= 16'sh0000;
      big_step_count_out <= 16'h0000;
    end else begin
      last_r <= ramped_reference_in;
      // A jump larger than one rpm means the ramp was bypassed.
      if (delta > 17'sh00001 || delta < -17'sh00001) begin
        big_step_count_out <= big_step_count_out + 16'h0001;
      end
    end
  end
endmodule

//--- tb/tb_jfr_ramp.sv
// Self-checking bench for the jog and fixed-speed reference ramp.
// Assumes one 40 MHz clock and a time unit shortened to one cycle.
`timescale 1ns/10ps
module tb_jfr_ramp;
  import jfr_pkg::*;
  logic               clock_in = 1'b0;
  logic               sys_rst_in = 1'b1;
  logic               jog_one = 1'b0, jog_two = 1'b0, load = 1'b0;
  logic        [15:0] mcw = 16'h0000, scale = 16'h4e20, nacc = 16'h0000, ndec = 16'h0000;
  logic signed [15:0] main_sp = 16'sh0000;
  logic               p1m = 1'b0, p1s = 1'b0, p2m = 1'b0, p2s = 1'b0;
  logic        [7:0]  mult = 8'h01;
  jfr_settings_t      set_in = '0, set_out;
  logic signed [15:0] applied, rin, rref;
  logic               jog_act;
  logic        [15:0] steps, steps0;
  int                 bad_count = 0, n_tests = 0, n, i, m;
  logic signed [15:0] exp_v;

  jfr_ramp #(.TIME_UNIT_CYCLES(1)) jfr_ramp_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .jog_command_one_in(jog_one), .jog_command_two_in(jog_two),
    .main_control_word_in(mcw), .main_speed_setpoint_in(main_sp),
    .path_one_multiplexer_in(p1m), .path_one_selector_in(p1s),
    .path_two_multiplexer_in(p2m), .path_two_selector_in(p2s),
    .active_speed_scale_in(scale), .ramp_duration_multiplier_in(mult),
    .normal_accel_duration_in(nacc), .normal_decel_duration_in(ndec),
    .settings_in(set_in), .settings_load_in(load), .settings_out(set_out),
    .applied_speed_setpoint_out(applied), .ramp_input_out(rin),
    .ramped_reference_out(rref), .jog_times_active_out(jog_act));
  jfr_ctrl_model jfr_ctrl_model_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .ramped_reference_in(rref), .big_step_count_out(steps));

  // The clock toggles every half period of 12.5 ns.
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  ////////////////////////////////////////////////////////////////////////////////
  // Clamp to +-10000 rpm, then to the scale limit, truncating.
  function automatic logic signed [15:0] lim_f(input logic [15:0] s, input int v);
    int l;
    l = (int'(s) * 32767) / 20000;
    if (v > 10000) v = 10000;
    if (v < -10000) v = -10000;
    if (v > l) v = l;
    if (v < -l) v = -l;
    return 16'(v);
  endfunction

  // Cycles to ramp by delta rpm with one time unit per cycle.
  function automatic int ramp_cyc(input int t, input int k, input int s, input int d);
    return (d * t * k) / s;
  endfunction

  // Compare one value and report a mismatch at once.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulse the load strobe for one cycle with new settings.
  task automatic load_set(input logic [15:0] a, d, input logic signed [15:0] s1, s2);
    @(posedge clock_in);
    set_in <= '{a, d, s1, s2};
    load   <= 1'b1;
    @(posedge clock_in);
    load   <= 1'b0;
  endtask

  // Count cycles until the ramped reference reaches v, bounded.
  task automatic wait_ref(input logic signed [15:0] v, output int c);
    c = 0;
    @(negedge clock_in);
    while (rref !== v && c < 2000) begin
      @(negedge clock_in);
      c++;
    end
    if (c >= 2000) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rref, v);
      wrap_up();
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(68));
    repeat (7) @(posedge clock_in);
    @(negedge clock_in);
    check(set_out, {16'h07d0, 16'h07d0, 32'h0});
    check(rref, 16'h0000);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    // Main path with random values and clamp corners.
    for (i = 0; i < 40; i++) begin
      @(posedge clock_in);
      main_sp <= (i < 2) ? ((i == 0) ? 16'sh7fff : 16'sh8000)
                         : 16'(int'($urandom_range(24000)) - 12000);
      scale   <= (i < 2) ? 16'h4e20 : 16'($urandom_range(9000));
      {p1m, p1s, p2m, p2s} <= 4'($urandom_range(15));
      @(posedge clock_in);
      @(negedge clock_in);
      exp_v = ((p1m && p1s) || (p2m && p2s)) ? lim_f(scale, main_sp) : 16'sh0000;
      check(applied, exp_v);
    end
    // Out-of-range settings are clamped on load.
    load_set(16'hffff, 16'h8000, 16'sh7fff, 16'sh8000);
    @(negedge clock_in);
    check(set_out, {16'h7530, 16'h7530, 16'sh2710, -16'sh2710});
    // Every jog source and mode, with zero ramp times.
    load_set(16'h0000, 16'h0000, 16'sh1388, -16'sh004d);
    scale   <= 16'h03e8;
    main_sp <= 16'sh01f4;
    {p1m, p1s} <= 2'b11;
    for (i = 0; i < 8; i++) begin
      @(posedge clock_in);
      m = i % 4;
      mcw     <= (i < 4) ? {6'h00, 2'(m), 8'h00} : 16'h0000;
      jog_one <= (i >= 4) && m[0];
      jog_two <= (i >= 4) && m[1];
      repeat ((i < 4) ? 1 : 3) @(posedge clock_in);
      @(negedge clock_in);
      exp_v = lim_f(scale, m[0] ? 5000 : (m[1] ? -77 : 500));
      check(rin, exp_v);
      check(jog_act, m != 0);
      @(negedge clock_in);
      check(rref, exp_v);
    end
    // Ramp timing with the multiplier stretching the jog times.
    @(posedge clock_in);
    jog_one <= 1'b0;
    jog_two <= 1'b0;
    {p1m, p1s, p2m, p2s} <= 4'h0;
    wait_ref(16'sh0000, n);
    load_set(16'h0064, 16'h0032, 16'sh0032, 16'sh000a);
    scale <= 16'h0064;
    mult  <= 8'h02;
    steps0 = steps;
    @(posedge clock_in);
    mcw <= 16'h0100;
    wait_ref(16'sh0032, n);
    check(n >= ramp_cyc(100, 2, 100, 50) - 3 && n <= ramp_cyc(100, 2, 100, 50) + 3, 1);
    @(posedge clock_in);
    mcw <= 16'h0200;
    wait_ref(16'sh000a, n);
    check(n >= ramp_cyc(50, 2, 100, 40) - 3 && n <= ramp_cyc(50, 2, 100, 40) + 3, 1);
    check(steps, steps0);
    @(posedge clock_in);
    mcw <= 16'h0000;
    @(negedge clock_in);
    @(negedge clock_in);
    check(jog_act, 1'b0);
    wrap_up();
  end
endmodule
